// [core/rsq_pkg.sv]
package rsq_pkg;

   // ****************************************
   // Widths and limits
   // ****************************************
   localparam int CAP_W = 8;
   localparam int RATE_W = 17;
   localparam int DIAG_BIT = 0;
   // Symbol rate limits in units of 10 symbol/s
   localparam logic [RATE_W-1:0] RATE_MAX_A = 17'h06D60;
   localparam logic [RATE_W-1:0] RATE_MAX_B = 17'h10BB5;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 50000000;
   localparam int TICK_HZ = 1000;
   localparam int TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int LONG_TO_MIN = 4;
   localparam int SHORT_TO_S = 30;
   localparam int LONG_TICKS = LONG_TO_MIN * 60 * TICK_HZ;
   localparam int SHORT_TICKS = SHORT_TO_S * TICK_HZ;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_SEL = 4'hC;
   localparam int CTRL_CCAPS_LSB = 0;
   localparam int CTRL_RCAPS_LSB = 8;
   localparam int CTRL_CLK_LSB = 16;
   localparam int CTRL_EARLY_BIT = 18;
   localparam int CTRL_RETRAIN_BIT = 19;
   localparam int STAT_CSTATE_LSB = 0;
   localparam int STAT_RSTATE_LSB = 4;
   localparam int STAT_CFAIL_BIT = 8;
   localparam int STAT_RFAIL_BIT = 9;
   localparam int STAT_CAPS_LSB = 16;
   localparam logic [CAP_W-1:0] CAPS_RST = 8'hFF;
   localparam logic [RATE_W+1:0] MODE_RST = 19'h00000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_HS1, ST_HS2, ST_ACTIVE
   } rsq_state_t;

   typedef enum logic [1:0] {
      CLK_M1, CLK_M2, CLK_M3A, CLK_M3B
   } rsq_clk_mode_t;

   typedef struct packed {
      logic fourWire;
      logic regionB;
      logic [RATE_W-1:0] symRate;
   } rsq_mode_t;

   typedef struct packed {
      logic start;
      logic regenStart;
      logic hsOk;
      logic hsFail;
      logic actDone;
      logic segFail;
      logic probeUsed;
      logic [CAP_W-1:0] rxCaps;
      logic [CAP_W-1:0] probeCaps;
      rsq_mode_t rxMode;
   } rsq_line_in_t;

   typedef struct packed {
      logic hsStart;
      logic deact;
      logic [CAP_W-1:0] caps;
      rsq_mode_t mode;
   } rsq_line_out_t;

endpackage

// [core/rsq_sequencer.sv]
// Function
// - Customer half idles; remote start goes to wait, office/regen start to session 1
// - Entering wait, customer half sends capabilities-available with its list
// - Sent list is own caps AND received caps AND probe caps when probed
// - Customer half takes office mode selection and uses exactly it next session
// - Customer half 4 minute timeout before Active: back to idle, report failure
// - Customer half session not succeeded in 30 s: report failure, idle
// - Diagnostic bit plus failure message in wait: pick mode, start session 2
// - Office half idles; remote training to session 1, office training to session 2
// - Entering wait, office half sends link-initiation to customer half
// - Entering Active, office half sends office-side-active to customer half
// - Clock mode 1 may raise active indication before activation completes
// - Clock modes 2, 3a, 3b hold active indication until activation completes
// - Office half advertises own caps AND caps from customer half; own caps alone when office start enters session 2
// - Active indication carries mode selection taken from its session
// - Office half 4 minute timeout before Active: idle, report failure
// - Office half session not succeeded in 30 s: report failure, idle
// - Diagnostic bit plus failure message in wait: office half starts session 2
// - Segment failure or retrain deactivates span, both halves return to idle
// - Every unit on the span selects the same data rate; diagnostic fallback uses REG_MODE at the customer half only
// - Symbol rate limited to 280 or 685.33 ksymbol/s by regional set; the diagnostic mode from REG_MODE is used without this check
module rsq_sequencer #(
   parameter int TICK_CYC = rsq_pkg::TICK_CYC,
   parameter int LONG_TICKS = rsq_pkg::LONG_TICKS,
   parameter int SHORT_TICKS = rsq_pkg::SHORT_TICKS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire rsq_pkg::rsq_line_in_t cLineIn,
   input wire rsq_pkg::rsq_line_in_t rLineIn,
   output rsq_pkg::rsq_line_out_t cLineOut,
   output rsq_pkg::rsq_line_out_t rLineOut,
   output rsq_pkg::rsq_state_t cState,
   output rsq_pkg::rsq_state_t rState
);

   localparam int DIV_W = $clog2(TICK_CYC + 1);
   localparam int CW = rsq_pkg::CAP_W;

   function automatic logic rateOk(rsq_pkg::rsq_mode_t m);
      rateOk = m.symRate <= (m.regionB ? rsq_pkg::RATE_MAX_B
                                       : rsq_pkg::RATE_MAX_A);
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [CW-1:0] cCaps_q, rCaps_q, capsMsg_q, rAdv_q;
   rsq_pkg::rsq_clk_mode_t clkMode_q;
   logic early_q, retrain_q, cFailSt_q, rFailSt_q;
   rsq_pkg::rsq_mode_t diagMode_q, cMode_q, rModeMsg_q;
   logic capsAvailV_q, cFailV_q, linkInitV_q, rActiveV_q, rFailV_q;
   logic cHsStart_q, rHsStart_q, cHsDone_q, rHsDone_q, rEarly_q;
   logic diagR_q, deact_q, tick_q;
   logic [DIV_W-1:0] div_q;
   logic [1:0] longRun, shortRun, longExp, shortExp;
   logic spanDown, cAbort, rAbort, wrEn, req;
   logic [31:0] rdMux;
   logic [CW-1:0] cInter;

   rsq_pkg::rsq_state_t cState_i, rState_i;
   assign cState = cState_i;
   assign rState = rState_i;

   // ****************************************
   // Millisecond tick
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == DIV_W'(TICK_CYC - 1)) begin
         div_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ****************************************
   // Timeouts per half
   // ****************************************
   assign longRun[0] = cState_i != rsq_pkg::ST_IDLE &&
                       cState_i != rsq_pkg::ST_ACTIVE;
   assign longRun[1] = rState_i != rsq_pkg::ST_IDLE &&
                       rState_i != rsq_pkg::ST_ACTIVE;
   assign shortRun[0] = (cState_i == rsq_pkg::ST_HS1 ||
                         cState_i == rsq_pkg::ST_HS2) && !cHsDone_q;
   assign shortRun[1] = (rState_i == rsq_pkg::ST_HS1 ||
                         rState_i == rsq_pkg::ST_HS2) && !rHsDone_q;

   generate
      for (genvar h = 0; h < 2; h++) begin : g_tmr
         rsq_timer #(.LIMIT(LONG_TICKS)) u_long (
            .clk(clk),
            .sys_rst(sys_rst),
            .tick(tick_q),
            .run(longRun[h]),
            .expired(longExp[h])
         );
         rsq_timer #(.LIMIT(SHORT_TICKS)) u_short (
            .clk(clk),
            .sys_rst(sys_rst),
            .tick(tick_q),
            .run(shortRun[h]),
            .expired(shortExp[h])
         );
      end
   endgenerate

   // ****************************************
   // Span deactivation and abort terms
   // ****************************************
   assign spanDown = cLineIn.segFail | rLineIn.segFail | retrain_q;
   assign cAbort = longExp[0] | shortExp[0] |
                   (shortRun[0] & cLineIn.hsFail);
   assign rAbort = longExp[1] | shortRun[1] & rLineIn.hsFail |
                   shortExp[1];
   assign cInter = cCaps_q & cLineIn.rxCaps &
                   (cLineIn.probeUsed ? cLineIn.probeCaps : '1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         deact_q <= 1'b0;
      end else begin
         deact_q <= spanDown;
      end
   end

   // ****************************************
   // Customer-side half
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cState_i <= rsq_pkg::ST_IDLE;
         capsAvailV_q <= 1'b0;
         cFailV_q <= 1'b0;
         cHsStart_q <= 1'b0;
         cHsDone_q <= 1'b0;
         capsMsg_q <= '0;
         cMode_q <= rsq_pkg::MODE_RST;
      end else begin
         capsAvailV_q <= 1'b0;
         cFailV_q <= 1'b0;
         cHsStart_q <= 1'b0;
         if (spanDown) begin
            cState_i <= rsq_pkg::ST_IDLE;
            cHsDone_q <= 1'b0;
         end else if (cAbort) begin
            cState_i <= rsq_pkg::ST_IDLE;
            cFailV_q <= 1'b1;
            cHsDone_q <= 1'b0;
         end else begin
            unique case (cState_i)
               rsq_pkg::ST_IDLE: begin
                  if (cLineIn.start) begin
                     cState_i <= rsq_pkg::ST_WAIT;
                     capsAvailV_q <= 1'b1;
                     capsMsg_q <= cInter;
                  end else if (cLineIn.regenStart || linkInitV_q) begin
                     cState_i <= rsq_pkg::ST_HS1;
                     cHsStart_q <= 1'b1;
                  end
               end
               rsq_pkg::ST_HS1: begin
                  if (cLineIn.hsOk) begin
                     cState_i <= rsq_pkg::ST_WAIT;
                     capsAvailV_q <= 1'b1;
                     capsMsg_q <= cInter;
                  end
               end
               rsq_pkg::ST_WAIT: begin
                  if (rActiveV_q && rateOk(rModeMsg_q)) begin
                     cState_i <= rsq_pkg::ST_HS2;
                     cMode_q <= rModeMsg_q;
                     cHsStart_q <= 1'b1;
                  end else if (rActiveV_q) begin
                     cState_i <= rsq_pkg::ST_IDLE;
                     cFailV_q <= 1'b1;
                  end else if (rFailV_q &&
                               capsMsg_q[rsq_pkg::DIAG_BIT]) begin
                     cState_i <= rsq_pkg::ST_HS2;
                     cMode_q <= diagMode_q;
                     cHsStart_q <= 1'b1;
                  end else if (rFailV_q) begin
                     cState_i <= rsq_pkg::ST_IDLE;
                  end
               end
               rsq_pkg::ST_HS2: begin
                  if (cLineIn.hsOk) begin
                     cHsDone_q <= 1'b1;
                  end
                  if (cHsDone_q && cLineIn.actDone) begin
                     cState_i <= rsq_pkg::ST_ACTIVE;
                     cHsDone_q <= 1'b0;
                  end
               end
               rsq_pkg::ST_ACTIVE: begin
                  if (rFailV_q) begin
                     cState_i <= rsq_pkg::ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Office-side half
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rState_i <= rsq_pkg::ST_IDLE;
         linkInitV_q <= 1'b0;
         rActiveV_q <= 1'b0;
         rFailV_q <= 1'b0;
         rHsStart_q <= 1'b0;
         rHsDone_q <= 1'b0;
         rEarly_q <= 1'b0;
         diagR_q <= 1'b0;
         rAdv_q <= rsq_pkg::CAPS_RST;
         rModeMsg_q <= rsq_pkg::MODE_RST;
      end else begin
         linkInitV_q <= 1'b0;
         rActiveV_q <= 1'b0;
         rFailV_q <= 1'b0;
         rHsStart_q <= 1'b0;
         if (spanDown) begin
            rState_i <= rsq_pkg::ST_IDLE;
            rHsDone_q <= 1'b0;
            rEarly_q <= 1'b0;
         end else if (rAbort) begin
            rState_i <= rsq_pkg::ST_IDLE;
            rFailV_q <= 1'b1;
            rHsDone_q <= 1'b0;
            rEarly_q <= 1'b0;
         end else begin
            unique case (rState_i)
               rsq_pkg::ST_IDLE: begin
                  if (rLineIn.start) begin
                     rState_i <= rsq_pkg::ST_HS2;
                     rAdv_q <= rCaps_q;
                     rHsStart_q <= 1'b1;
                  end else if (capsAvailV_q) begin
                     rState_i <= rsq_pkg::ST_HS1;
                     rAdv_q <= rCaps_q & capsMsg_q;
                     rHsStart_q <= 1'b1;
                  end
               end
               rsq_pkg::ST_HS2: begin
                  if (rLineIn.hsOk) begin
                     rState_i <= rsq_pkg::ST_WAIT;
                     linkInitV_q <= 1'b1;
                     diagR_q <= rLineIn.rxCaps[rsq_pkg::DIAG_BIT];
                  end
               end
               rsq_pkg::ST_WAIT: begin
                  if (capsAvailV_q) begin
                     rState_i <= rsq_pkg::ST_HS1;
                     rAdv_q <= rCaps_q & capsMsg_q;
                     rHsStart_q <= 1'b1;
                  end else if (cFailV_q && diagR_q) begin
                     rState_i <= rsq_pkg::ST_HS2;
                     rHsStart_q <= 1'b1;
                  end else if (cFailV_q) begin
                     rState_i <= rsq_pkg::ST_IDLE;
                  end
               end
               rsq_pkg::ST_HS1: begin
                  if (!rHsDone_q && rLineIn.hsOk) begin
                     if (!rateOk(rLineIn.rxMode)) begin
                        rState_i <= rsq_pkg::ST_IDLE;
                        rFailV_q <= 1'b1;
                     end else begin
                        rHsDone_q <= 1'b1;
                        rModeMsg_q <= rLineIn.rxMode;
                        if (clkMode_q == rsq_pkg::CLK_M1 && early_q) begin
                           rActiveV_q <= 1'b1;
                           rEarly_q <= 1'b1;
                        end
                     end
                  end else if (rHsDone_q && rLineIn.actDone) begin
                     rState_i <= rsq_pkg::ST_ACTIVE;
                     rActiveV_q <= !rEarly_q;
                     rHsDone_q <= 1'b0;
                     rEarly_q <= 1'b0;
                  end
               end
               rsq_pkg::ST_ACTIVE: begin
                  if (cFailV_q) begin
                     rState_i <= rsq_pkg::ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Line-side outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cLineOut <= '0;
         rLineOut <= '0;
      end else begin
         cLineOut <= '{cHsStart_q, deact_q, cCaps_q, cMode_q};
         rLineOut <= '{rHsStart_q, deact_q, rAdv_q, rModeMsg_q};
      end
   end

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   assign req = avs_read | avs_write;
   assign wrEn = avs_write & !avs_waitrequest;

   always_comb begin
      rdMux = 32'h00000000;
      unique case (avs_address)
         rsq_pkg::REG_CTRL: begin
            rdMux[rsq_pkg::CTRL_CCAPS_LSB +: CW] = cCaps_q;
            rdMux[rsq_pkg::CTRL_RCAPS_LSB +: CW] = rCaps_q;
            rdMux[rsq_pkg::CTRL_CLK_LSB +: 2] = clkMode_q;
            rdMux[rsq_pkg::CTRL_EARLY_BIT] = early_q;
         end
         rsq_pkg::REG_MODE: rdMux[18:0] = diagMode_q;
         rsq_pkg::REG_STAT: begin
            rdMux[rsq_pkg::STAT_CSTATE_LSB +: 3] = cState_i;
            rdMux[rsq_pkg::STAT_RSTATE_LSB +: 3] = rState_i;
            rdMux[rsq_pkg::STAT_CFAIL_BIT] = cFailSt_q;
            rdMux[rsq_pkg::STAT_RFAIL_BIT] = rFailSt_q;
            rdMux[rsq_pkg::STAT_CAPS_LSB +: CW] = capsMsg_q;
         end
         rsq_pkg::REG_SEL: rdMux[18:0] = cMode_q;
         default: rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdMux;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cCaps_q <= rsq_pkg::CAPS_RST;
         rCaps_q <= rsq_pkg::CAPS_RST;
         clkMode_q <= rsq_pkg::CLK_M1;
         early_q <= 1'b0;
         retrain_q <= 1'b0;
         diagMode_q <= rsq_pkg::MODE_RST;
      end else begin
         retrain_q <= 1'b0;
         if (wrEn && avs_address == rsq_pkg::REG_CTRL) begin
            cCaps_q <= avs_writedata[rsq_pkg::CTRL_CCAPS_LSB +: CW];
            rCaps_q <= avs_writedata[rsq_pkg::CTRL_RCAPS_LSB +: CW];
            clkMode_q <= rsq_pkg::rsq_clk_mode_t'(
               avs_writedata[rsq_pkg::CTRL_CLK_LSB +: 2]);
            early_q <= avs_writedata[rsq_pkg::CTRL_EARLY_BIT];
            retrain_q <= avs_writedata[rsq_pkg::CTRL_RETRAIN_BIT];
         end
         if (wrEn && avs_address == rsq_pkg::REG_MODE) begin
            diagMode_q <= avs_writedata[18:0];
         end
      end
   end

   // Sticky failure flags, set wins over write-one clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cFailSt_q <= 1'b0;
         rFailSt_q <= 1'b0;
      end else begin
         cFailSt_q <= cFailV_q | cFailSt_q & !(wrEn &&
            avs_address == rsq_pkg::REG_STAT &&
            avs_writedata[rsq_pkg::STAT_CFAIL_BIT]);
         rFailSt_q <= rFailV_q | rFailSt_q & !(wrEn &&
            avs_address == rsq_pkg::REG_STAT &&
            avs_writedata[rsq_pkg::STAT_RFAIL_BIT]);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   c_start_a: assert property (cState_i == rsq_pkg::ST_IDLE && cLineIn.start
      && !spanDown && !cAbort |=> cState_i == rsq_pkg::ST_WAIT
      && capsAvailV_q) else $error("customer start path wrong");
   caps_inter_a: assert property (capsAvailV_q |-> (capsMsg_q
      & ~$past(cCaps_q)) == '0) else $error("caps not subset");
   mode_copy_a: assert property (cState_i == rsq_pkg::ST_WAIT && rActiveV_q
      && rateOk(rModeMsg_q) && !spanDown && !cAbort |=> cHsStart_q
      && cMode_q == $past(rModeMsg_q)) else $error("mode not copied");
   c_timeout_a: assert property (longExp[0] && !spanDown |=>
      cState_i == rsq_pkg::ST_IDLE && cFailV_q)
      else $error("customer timeout ignored");
   r_short_a: assert property (shortExp[1] && !spanDown |=>
      rState_i == rsq_pkg::ST_IDLE ##1 rFailSt_q)
      else $error("office session timeout ignored");
   c_diag_a: assert property (cState_i == rsq_pkg::ST_WAIT && rFailV_q
      && !rActiveV_q && capsMsg_q[rsq_pkg::DIAG_BIT] && !spanDown
      && !cAbort |=> cState_i == rsq_pkg::ST_HS2 && cHsStart_q)
      else $error("diagnostic fallback missed");
   link_init_a: assert property (rState_i == rsq_pkg::ST_WAIT
      && $past(rState_i) == rsq_pkg::ST_HS2 |-> linkInitV_q)
      else $error("link initiation missing");
   active_gate_a: assert property (rActiveV_q && clkMode_q !=
      rsq_pkg::CLK_M1 |-> rState_i == rsq_pkg::ST_ACTIVE)
      else $error("active raised early");
   span_down_a: assert property (spanDown |=> cState_i == rsq_pkg::ST_IDLE
      && rState_i == rsq_pkg::ST_IDLE ##1 cLineOut.deact)
      else $error("span not deactivated");
   r_adv_a: assert property (rHsStart_q && rState_i == rsq_pkg::ST_HS1
      |-> (rAdv_q & ~(rCaps_q & capsMsg_q)) == '0)
      else $error("office caps not intersected");
   strobe_a: assert property (capsAvailV_q |=> !capsAvailV_q)
      else $error("message strobe too long");

   both_active_c: cover property (cState_i == rsq_pkg::ST_ACTIVE
      && rState_i == rsq_pkg::ST_ACTIVE);
   diag_c: cover property (cState_i == rsq_pkg::ST_WAIT ##1
      cState_i == rsq_pkg::ST_HS2 && rFailV_q == 1'b0);
   early_c: cover property (rEarly_q && rState_i == rsq_pkg::ST_HS1);
   timeout_c: cover property (longExp[1]);

endmodule

// [core/rsq_timer.sv]
module rsq_timer #(
   parameter int LIMIT = 30000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic run,
   output logic expired
);

   localparam int W = $clog2(LIMIT + 1);

   logic [W-1:0] count_q;

   // ****************************************
   // Tick counter, cleared while idle
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         count_q <= '0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (tick) begin
            if (count_q == W'(LIMIT - 1)) begin
               count_q <= '0;
               expired <= 1'b1;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end

endmodule

// [verif/rsq_line_model.sv]
// ****
// Line transceiver model at one half's far side
// ****
module rsq_line_model #(
   parameter logic [7:0] CAPS = 8'hFF,
   parameter logic [18:0] MODE = 19'h01234
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic kick,
   input wire logic mute,
   input wire rsq_pkg::rsq_line_out_t lineOut,
   output rsq_pkg::rsq_line_in_t lineIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cntQ;
   always_ff @(posedge clk) begin
      lineIn <= '0;
      lineIn.rxCaps <= CAPS;
      lineIn.probeCaps <= 8'hFB;
      lineIn.probeUsed <= 1'b1;
      lineIn.rxMode <= MODE;
      lineIn.start <= kick;
      if (sys_rst || lineOut.deact || cntQ == 4'h7) cntQ <= 4'h0;
      else if (lineOut.hsStart && !mute) cntQ <= 4'h1;
      else if (cntQ != 4'h0) cntQ <= cntQ + 4'h1;
      if (cntQ == 4'h5) lineIn.hsOk <= 1'b1;
      if (cntQ == 4'h7) lineIn.actDone <= 1'b1;
   end
endmodule

// [verif/tb_rsq_sequencer.sv]
// ****
// Bench for the start-up sequencer
// ****
module tb_rsq_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, cKick = 0, rKick = 0, cMute = 0, rMute = 0;
   rsq_pkg::rsq_line_in_t cIn, rIn;
   rsq_pkg::rsq_line_out_t cOut, rOut;
   rsq_pkg::rsq_state_t cSt, rSt;
   int err_count = 0, samples_checked = 0, deactSeen = 0;
   always #10 clk = ~clk;
   always @(posedge clk)
      if (rOut.deact === 1'b1 && cOut.deact === 1'b1) deactSeen++;
   rsq_sequencer #(.TICK_CYC(4), .LONG_TICKS(40), .SHORT_TICKS(10))
   u_rsq_sequencer (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cLineIn(cIn), .rLineIn(rIn),
      .cLineOut(cOut), .rLineOut(rOut), .cState(cSt), .rState(rSt));
   rsq_line_model #(.CAPS(8'hBF)) u_c_model (.clk(clk), .sys_rst(sys_rst),
      .kick(cKick), .mute(cMute), .lineOut(cOut), .lineIn(cIn));
   rsq_line_model #(.CAPS(8'hFF)) u_r_model (.clk(clk), .sys_rst(sys_rst),
      .kick(rKick), .mute(rMute), .lineOut(rOut), .lineIn(rIn));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitSt(input logic r, input rsq_pkg::rsq_state_t s,
         input int lim);
      int n;
      n = 0;
      while ((r ? rSt : cSt) !== s && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("state", {29'h0, r ? rSt : cSt}, {29'h0, s});
   endtask
   task automatic kickC();
      cKick <= 1'b1;
      @(posedge clk);
      cKick <= 1'b0;
   endtask
   task automatic t_reset();
      bus(0, rsq_pkg::REG_CTRL, 32'h0);
      chk("ctrl", rd, 32'h0000FFFF);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("stat", rd & 32'h3FF, 32'h0);
      bus(0, 4'h2, 32'h0);
      chk("unmapped", rd, 32'h0);
   endtask
   task automatic t_normal();
      bus(1, rsq_pkg::REG_CTRL, 32'h00007EF6);
      kickC();
      waitSt(0, rsq_pkg::ST_WAIT, 5);
      waitSt(1, rsq_pkg::ST_HS1, 5);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("list", rd[23:16], 8'hB2);
      chk("rcaps", rOut.caps, 8'h32);
      waitSt(1, rsq_pkg::ST_ACTIVE, 30);
      waitSt(0, rsq_pkg::ST_HS2, 5);
      waitSt(0, rsq_pkg::ST_ACTIVE, 30);
      chk("cmode", cOut.mode, 19'h01234);
      chk("rmode", rOut.mode, 19'h01234);
      bus(0, rsq_pkg::REG_SEL, 32'h0);
      chk("sel", rd, 32'h00001234);
   endtask
   task automatic t_retrain();
      deactSeen = 0;
      bus(1, rsq_pkg::REG_CTRL, 32'h00087EF6);
      waitSt(0, rsq_pkg::ST_IDLE, 5);
      waitSt(1, rsq_pkg::ST_IDLE, 5);
      repeat (3) @(posedge clk);
      chk("deact", deactSeen > 0, 1);
   endtask
   task automatic t_timeout();
      rMute <= 1'b1;
      kickC();
      waitSt(1, rsq_pkg::ST_HS1, 10);
      waitSt(1, rsq_pkg::ST_IDLE, 100);
      waitSt(0, rsq_pkg::ST_IDLE, 20);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("rfail", rd[9], 1'b1);
      bus(1, rsq_pkg::REG_STAT, 32'h00000300);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("clear", rd[9:8], 2'h0);
      rMute <= 1'b0;
   endtask
   task automatic t_diag();
      bus(1, rsq_pkg::REG_CTRL, 32'h00007EF7);
      bus(1, rsq_pkg::REG_MODE, 32'h00050123);
      rMute <= 1'b1;
      cMute <= 1'b1;
      kickC();
      waitSt(0, rsq_pkg::ST_HS2, 80);
      bus(0, rsq_pkg::REG_SEL, 32'h0);
      chk("diagsel", rd, 32'h00050123);
      waitSt(0, rsq_pkg::ST_IDLE, 80);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("dfail", rd[9:8], 2'h3);
      bus(1, rsq_pkg::REG_STAT, 32'h00000300);
      rMute <= 1'b0;
      cMute <= 1'b0;
   endtask
   task automatic t_long();
      rKick <= 1'b1;
      kickC();
      rKick <= 1'b0;
      waitSt(1, rsq_pkg::ST_HS2, 5);
      waitSt(1, rsq_pkg::ST_WAIT, 20);
      chk("cwait", cSt, rsq_pkg::ST_WAIT);
      waitSt(0, rsq_pkg::ST_IDLE, 200);
      waitSt(1, rsq_pkg::ST_IDLE, 5);
      repeat (2) @(posedge clk);
      bus(0, rsq_pkg::REG_STAT, 32'h0);
      chk("lfail", rd[9:8], 2'h3);
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_normal();
      t_retrain();
      t_timeout();
      t_diag();
      t_long();
      test_done();
   end
endmodule
